// File: pac_adc_ctrl.v
/*
 * digital control of a self-calibrating pipelined 14-bit converter:
 * pin sampling, reset/calibration/power-down sequencing, output word
 * and valid flag, and an apb register slave.
 * assumes all pins are asynchronous to pclk and the sample clock is far
 * slower than pclk (2.5 MHz max against 40 MHz).
 */
// Local design decisions: the APB slave port and the placing of the registers.
// Summary of operation
// RULE1 - host keeps sample clock in range
// RULE2 - sample clock steps the state machine
// RULE3 - host holds reset high two cycles
// RULE4 - host holds calibration high two cycles
// RULE5 - host resets before requesting calibration
// RULE6 - host recalibrates on temperature drift, wake
// RULE7 - host calibrates at conversion clock rate
// RULE8 - calibration lasts fixed cycle count
// RULE9 - outputs meaningless during reset, calibration, thirteen after
// RULE10 - host waits reference settling before calibration
// RULE11 - data drivers enabled only while read low
// RULE12 - power-down held low; wake after delay
// RULE13 - power-down corrupts pipeline; reset, calibrate after
// RULE14 - valid low whenever data valid, not reset
// RULE15 - two's complement word plus valid output
// RULE16 - host latches data on rising edge
// RULE17 - sample falling edge, thirteen-cycle latency
// RULE18 - out-of-range input saturates output word
`timescale 1ns/10ps
`include "pac_adc_regs.vh"

module pac_adc_ctrl #(
    parameter CAL_CYCLES = `PAC_CAL_CYCLES,
    parameter WAKE_CYCLES = `PAC_WAKE_CYCLES
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [3:0] paddr,
    input wire [31:0] pwdata,
    output wire pready,
    output wire pslverr,
    output wire [31:0] prdata,
    input wire sample_clk,
    input wire conv_reset,
    input wire cal_req,
    input wire read_n,
    input wire power_down_n,
    input wire signed [15:0] analog_in,
    output wire [13:0] data_out,
    output wire data_oe,
    output wire valid_n
);

    // ==========================================
    // state codes
    localparam ST_PDN = 3'h0;
    localparam ST_WAKE = 3'h1;
    localparam ST_RUN = 3'h2;
    localparam ST_RST = 3'h3;
    localparam ST_CAL = 3'h4;

    // ==========================================
    // pin sampling: three stages, change accepted when stages 2 and 3 agree
    wire [4:0] pin_raw = {power_down_n, read_n, cal_req, conv_reset, sample_clk};
    reg [4:0] sync1_r;
    reg [4:0] sync2_r;
    reg [4:0] sync3_r;
    reg [4:0] pin_r;
    wire [4:0] pin_nxt = (sync2_r & sync3_r) | (pin_r & (sync2_r | sync3_r));

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            // pins taken as idle: read high, power-down high, reset and calibration low
            sync1_r <= 5'h18;
            sync2_r <= 5'h18;
            sync3_r <= 5'h18;
            pin_r <= 5'h18;
        end else begin
            sync1_r <= pin_raw;
            sync2_r <= sync1_r;
            sync3_r <= sync2_r;
            pin_r <= pin_nxt;
        end
    end

    // ==========================================
    // sample clock edges
    reg sclk_d_r;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sclk_d_r <= 1'b0;
        end else begin
            sclk_d_r <= pin_r[0];
        end
    end
    // state machine moves only on sample clock rises, or at once on power-down; a stalled clock freezes it otherwise
    wire srise = pin_r[0] & ~sclk_d_r; // [RULE2]
    wire sfall = ~pin_r[0] & sclk_d_r; // [RULE17]

    // ==========================================
    // control register and combined request levels
    reg [2:0] ctrl_r;
    wire rst_lvl = pin_r[1] | ctrl_r[`PAC_CTRL_RESET_BIT];
    wire cal_lvl = pin_r[2] | ctrl_r[`PAC_CTRL_CAL_BIT];
    wire pd_act = ~pin_r[4] | ctrl_r[`PAC_CTRL_PD_BIT];

    // ==========================================
    // sequencer
    reg [2:0] state_r;
    reg [2:0] state_nxt;
    reg [1:0] rst_hi_r;
    reg [1:0] cal_hi_r;
    reg [18:0] cnt_r;
    reg [18:0] cnt_nxt;
    reg [3:0] settle_r;
    reg [3:0] settle_nxt;
    reg reset_done_r;
    reg reset_done_nxt;
    reg cal_done_r;
    reg cal_done_nxt;

    wire rst_ok = (rst_hi_r == `PAC_MIN_PULSE);
    wire cal_ok = (cal_hi_r == `PAC_MIN_PULSE);

    always @* begin
        state_nxt = state_r;
        cnt_nxt = cnt_r;
        settle_nxt = settle_r;
        reset_done_nxt = reset_done_r;
        cal_done_nxt = cal_done_r;
        if (pd_act) begin
            state_nxt = ST_PDN; // [RULE12]
            settle_nxt = 4'h0;
            reset_done_nxt = 1'b0; // [RULE13]
            cal_done_nxt = 1'b0; // [RULE13]
        end else if (srise) begin
            case (state_r)
                ST_PDN: begin
                    state_nxt = ST_WAKE;
                    cnt_nxt = WAKE_CYCLES[18:0];
                end
                ST_WAKE: begin
                    if (cnt_r <= 19'h00001) begin
                        state_nxt = ST_RUN; // [RULE12]
                    end
                    cnt_nxt = cnt_r - 19'h00001;
                end
                ST_RUN: begin
                    if (rst_lvl) begin
                        state_nxt = ST_RST;
                        settle_nxt = 4'h0; // [RULE9]
                    end else if (cal_lvl) begin
                        state_nxt = ST_CAL;
                        settle_nxt = 4'h0; // [RULE9]
                        cnt_nxt = 19'h00000;
                    end else if (settle_r != `PAC_BLANK_CYCLES) begin
                        settle_nxt = settle_r + 4'h1; // [RULE9]
                    end
                end
                ST_RST: begin
                    settle_nxt = 4'h0;
                    if (!rst_lvl) begin
                        state_nxt = ST_RUN;
                        if (rst_ok) begin
                            reset_done_nxt = 1'b1;
                            cal_done_nxt = 1'b0;
                        end
                    end
                end
                ST_CAL: begin
                    settle_nxt = 4'h0; // [RULE9]
                    if (cnt_r == 19'h00000) begin
                        // request phase: too short, or no prior reset, is dropped
                        if (!cal_lvl) begin
                            if (cal_ok && reset_done_r) begin
                                cnt_nxt = CAL_CYCLES[18:0]; // [RULE8]
                            end else begin
                                state_nxt = ST_RUN;
                            end
                        end
                    end else if (cnt_r == 19'h00001) begin
                        state_nxt = ST_RUN; // [RULE8]
                        cal_done_nxt = 1'b1;
                        cnt_nxt = 19'h00000;
                    end else begin
                        cnt_nxt = cnt_r - 19'h00001; // [RULE8]
                    end
                end
                default: begin
                    state_nxt = ST_PDN;
                end
            endcase
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_PDN;
            cnt_r <= 19'h00000;
            settle_r <= 4'h0;
            reset_done_r <= 1'b0;
            cal_done_r <= 1'b0;
            rst_hi_r <= 2'h0;
            cal_hi_r <= 2'h0;
        end else begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
            settle_r <= settle_nxt;
            reset_done_r <= reset_done_nxt;
            cal_done_r <= cal_done_nxt;
            if (srise) begin
                // high time counted in sample cycles, saturating at the minimum
                if (!rst_lvl) begin
                    rst_hi_r <= 2'h0;
                end else if (!rst_ok) begin
                    rst_hi_r <= rst_hi_r + 2'h1; // [RULE3]
                end
                if (!cal_lvl) begin
                    cal_hi_r <= 2'h0;
                end else if (!cal_ok) begin
                    cal_hi_r <= cal_hi_r + 2'h1; // [RULE4]
                end
            end
        end
    end

    // ==========================================
    // data path
    wire [13:0] pipe_word;
    reg [13:0] data_r;
    reg valid_r;

    pac_pipe u_pipe (
        .pclk(pclk),
        .presetn(presetn),
        .shift(sfall & ~pd_act),
        .sample_in(analog_in),
        .word_out(pipe_word)
    );

    // word changes on the sample clock rise; flag sets there but clears at once on reset, calibration or power-down
    wire word_good = (state_r == ST_RUN) & ~rst_lvl & ~cal_lvl & (settle_r == `PAC_BLANK_CYCLES);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_r <= 14'h0000;
            valid_r <= 1'b0;
        end else begin
            if (srise) begin
                data_r <= pipe_word; // [RULE17]
            end
            // calibration level drops valid at once, not at the next sample rise
            if (rst_lvl || cal_lvl || pd_act) begin
                valid_r <= 1'b0; // [RULE9] [RULE14]
            end else if (srise) begin
                valid_r <= word_good; // [RULE14]
            end
        end
    end

    assign data_out = data_r; // [RULE15]
    assign valid_n = ~valid_r; // [RULE14]
    // drivers follow the read level; tri-state is resolved outside
    assign data_oe = ~pin_r[3]; // [RULE11]

    // ==========================================
    // apb slave: zero wait, read data captured in the setup cycle
    reg [31:0] rdata_r;
    reg [31:0] rdata_nxt;
    wire setup = psel & ~penable;
    wire mapped = (paddr == `PAC_OFS_CTRL) | (paddr == `PAC_OFS_STATUS) |
                  (paddr == `PAC_OFS_DATA) | (paddr == `PAC_OFS_CALCNT);

    always @* begin
        rdata_nxt = 32'h00000000;
        case (paddr)
            `PAC_OFS_CTRL: rdata_nxt = {29'h00000000, ctrl_r};
            `PAC_OFS_STATUS: rdata_nxt = {24'h000000, data_oe, pd_act, valid_r, cal_done_r, reset_done_r, state_r};
            `PAC_OFS_DATA: rdata_nxt = {18'h00000, data_r};
            `PAC_OFS_CALCNT: rdata_nxt = {13'h0000, cnt_r};
            default: rdata_nxt = 32'h00000000;
        endcase
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata_r <= 32'h00000000;
            ctrl_r <= `PAC_CTRL_RST_VAL;
        end else begin
            if (setup) begin
                rdata_r <= rdata_nxt;
            end
            if (psel && penable && pwrite && (paddr == `PAC_OFS_CTRL)) begin
                ctrl_r <= pwdata[2:0];
            end
        end
    end

    assign pready = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    assign prdata = rdata_r;

endmodule // pac_adc_ctrl

// File: pac_adc_regs.vh
/*
 * constants for the pipelined converter control block: register offsets,
 * control bit positions, reset values and cycle counts.
 * assumes inclusion by bare name from the design files.
 */
`ifndef PAC_ADC_REGS_VH
`define PAC_ADC_REGS_VH

// ==========================================
// register offsets (byte addresses)
`define PAC_OFS_CTRL 4'h0
`define PAC_OFS_STATUS 4'h4
`define PAC_OFS_DATA 4'h8
`define PAC_OFS_CALCNT 4'hc

// ==========================================
// control register fields
`define PAC_CTRL_RESET_BIT 0
`define PAC_CTRL_CAL_BIT 1
`define PAC_CTRL_PD_BIT 2
`define PAC_CTRL_RST_VAL 3'h0

// ==========================================
// status register fields
`define PAC_ST_STATE_LSB 0
`define PAC_ST_RESET_DONE_BIT 3
`define PAC_ST_CAL_DONE_BIT 4
`define PAC_ST_VALID_BIT 5
`define PAC_ST_PD_BIT 6
`define PAC_ST_OE_BIT 7

// ==========================================
// counts, in sample clock cycles, and the data word width
`define PAC_CAL_CYCLES 272800
`define PAC_MIN_PULSE 2'h2
`define PAC_LATENCY 13
`define PAC_BLANK_CYCLES 4'hd
`define PAC_WAKE_CYCLES 16
`define PAC_DATA_W 14

`endif

// File: pac_pipe.v
/*
 * conversion pipeline: saturates each acquired sample to 14 bits and
 * delays it by the fixed pipeline depth.
 * assumes the caller pulses shift once per sample clock falling edge.
 */
`timescale 1ns/10ps
`include "pac_adc_regs.vh"

module pac_pipe (
    input wire pclk,
    input wire presetn,
    input wire shift,
    input wire signed [15:0] sample_in,
    output wire [13:0] word_out
);

    // ==========================================
    // saturation
    function [13:0] sat14;
        input signed [15:0] v;
        begin
            if (v > 16'sh1fff) begin
                sat14 = 14'h1fff; // [RULE18]
            end else if (v < -16'sh2000) begin
                sat14 = 14'h2000; // [RULE18]
            end else begin
                sat14 = v[13:0]; // [RULE15]
            end
        end
    endfunction

    // ==========================================
    // delay line
    reg [13:0] stage_r [0:`PAC_LATENCY-1];
    integer i;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < `PAC_LATENCY; i = i + 1) begin
                stage_r[i] <= 14'h0000;
            end
        end else if (shift) begin
            stage_r[0] <= sat14(sample_in);
            for (i = 1; i < `PAC_LATENCY; i = i + 1) begin
                stage_r[i] <= stage_r[i-1]; // [RULE17]
            end
        end
    end

    assign word_out = stage_r[`PAC_LATENCY-1];

endmodule // pac_pipe

// File: pac_adc_chk.sv
/* checker for the converter control block: pin-side timing relations.
   assumes bind onto pac_adc_ctrl; pclk is the only clock. */
`timescale 1ns/10ps
module pac_adc_chk (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pready,
    input wire pslverr,
    input wire sample_clk,
    input wire conv_reset,
    input wire cal_req,
    input wire read_n,
    input wire power_down_n,
    input wire [13:0] data_out,
    input wire data_oe,
    input wire valid_n
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // ==========================================
    // pins: six cycles covers sync plus agreement
    oe_on_a: assert property ((!read_n) [*6] |-> data_oe) else $error("drivers off while read low");
    oe_off_a: assert property (read_n [*6] |-> !data_oe) else $error("drivers on while read high");
    rst_blank_a: assert property (conv_reset [*6] |-> valid_n) else $error("valid during reset");
    cal_blank_a: assert property (cal_req [*6] |-> valid_n) else $error("valid during calibration");
    pd_blank_a: assert property ((!power_down_n) [*6] |-> valid_n) else $error("valid in power-down");
    // word changes and valid_n falls only shortly after a sample rise
    word_edge_a: assert property ($changed(data_out) |-> sample_clk && !$past(sample_clk, 8))
        else $error("word moved off a sample rise");
    valid_edge_a: assert property ($fell(valid_n) |-> sample_clk) else $error("valid fell off a rise");
    // ==========================================
    // apb
    apb_ready_a: assert property (psel && penable |-> pready) else $error("no zero-wait ready");
    err_phase_a: assert property (pslverr |-> psel && penable) else $error("error outside access");
endmodule // pac_adc_chk

// File: pac_host.sv
/* host model: sample clock, analog stimulus and word capture.
   assumes pclk at 40 MHz; sample clock is pclk/16, 2.5 MHz. */
`timescale 1ns/10ps
module pac_host (
    input wire pclk,
    input wire [15:0] ain_next,
    input wire [13:0] data_out,
    input wire data_oe,
    input wire valid_n,
    output reg sample_clk = 1'b0,
    output reg signed [15:0] analog_in = 16'sh0,
    output reg rise_ev = 1'b0,
    output reg fall_ev = 1'b0,
    output reg [13:0] cap_word = 14'h0,
    output reg cap_valid_n = 1'b1
);
    reg [3:0] div_r = 4'h0;
    // released bus shows the inverse, not the old word
    wire [13:0] bus_w = data_oe ? data_out : ~data_out;
    // free-running at the top rate, same rate for calibration
    always @(posedge pclk) begin
        div_r <= div_r + 4'h1;
        rise_ev <= (div_r == 4'h7);
        fall_ev <= (div_r == 4'hf);
        if (div_r == 4'h7) begin
            sample_clk <= 1'b1;
            analog_in <= ain_next; // moved at rise, far from fall detection
            cap_word <= bus_w;
            cap_valid_n <= valid_n;
        end
        if (div_r == 4'hf) sample_clk <= 1'b0;
    end
endmodule // pac_host

// File: pac_adc_ctrl_tb.sv
/* self-checking bench for pac_adc_ctrl with a queue model of the pipeline.
   assumes pac_host and pac_adc_chk compiled first. */
`timescale 1ns/10ps
`include "pac_adc_regs.vh"
module pac_adc_ctrl_tb;
    localparam CALN = 20;
    reg pclk = 1'b0;
    reg presetn = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [3:0] paddr = 4'h0;
    reg [31:0] pwdata = 32'h0;
    reg conv_reset = 1'b0;
    reg cal_req = 1'b0;
    reg read_n = 1'b0;
    reg power_down_n = 1'b1;
    reg [15:0] ain = 16'h0;
    reg [19:0] lfsr = 20'd92192;
    reg [31:0] rd;
    reg perr;
    reg [2:0] hold_st;
    reg [13:0] q[$];
    wire pready, pslverr, sample_clk, data_oe, valid_n, rise_ev, fall_ev, cap_valid_n;
    wire [31:0] prdata;
    wire [13:0] data_out, cap_word;
    wire signed [15:0] analog_in;
    integer err_count = 0;
    integer n_checks = 0;
    integer i;
    always #12.5 pclk = ~pclk;
    pac_adc_ctrl #(.CAL_CYCLES(CALN), .WAKE_CYCLES(2)) DUT (.pclk, .presetn, .psel, .penable, .pwrite,
        .paddr, .pwdata, .pready, .pslverr, .prdata, .sample_clk, .conv_reset, .cal_req, .read_n,
        .power_down_n, .analog_in, .data_out, .data_oe, .valid_n);
    pac_host host (.pclk, .ain_next(ain), .data_out, .data_oe, .valid_n, .sample_clk, .analog_in,
        .rise_ev, .fall_ev, .cap_word, .cap_valid_n);
    function [19:0] lfsr_next(input [19:0] s);
        lfsr_next = {s[18:0], s[19] ^ s[16]};
    endfunction
    function [13:0] sat(input signed [15:0] v);
        sat = (v > 16'sd8191) ? 14'h1fff : (v < -16'sd8192) ? 14'h2000 : v[13:0];
    endfunction
    task close_out;
        if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    task chk(input [31:0] got, input [31:0] exp);
        n_checks = n_checks + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // ==========================================
    // pipeline model: one word per fall, fourteen deep at capture
    always @(posedge pclk) begin
        if (fall_ev) begin
            q.push_back(sat(analog_in));
            if (q.size() > 14) q.pop_front();
        end
        if (!power_down_n) q.delete();
        if (rise_ev) begin
            lfsr = lfsr_next(lfsr);
            ain <= lfsr[15:0];
            if (cap_valid_n === 1'b0 && read_n === 1'b0 && q.size() == 14) chk(cap_word, q[0]);
        end
    end
    task ev(input integer n, input r);
        integer k, j;
        for (k = 0; k < n; k = k + 1) begin
            j = 0;
            do begin
                @(posedge pclk);
                j = j + 1;
            end while ((r ? rise_ev : fall_ev) !== 1'b1 && j < 40);
            if ((r ? rise_ev : fall_ev) !== 1'b1) begin
                err_count = err_count + 1;
                close_out;
            end
        end
    endtask
    task apb(input wr, input [3:0] a, input [31:0] d);
        integer j;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        j = 0;
        do begin
            @(posedge pclk);
            j = j + 1;
        end while (pready !== 1'b1 && j < 20);
        if (pready !== 1'b1) begin
            err_count = err_count + 1;
            close_out;
        end
        rd = prdata;
        perr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // level pulse held for n sample rises, changed only after a fall
    task pulse(input c, input integer n);
        ev(1, 0);
        if (c) cal_req <= 1'b1; else conv_reset <= 1'b1;
        ev(n, 1);
        apb(0, `PAC_OFS_STATUS, 0);
        hold_st = rd[2:0];
        ev(1, 0);
        cal_req <= 1'b0;
        conv_reset <= 1'b0;
    endtask
    task vwatch(input integer lo, input integer hi);
        for (i = 1; i <= hi; i = i + 1) begin
            ev(1, 1);
            if (i <= lo || i == hi) chk(cap_valid_n, i <= lo);
        end
    endtask
    // ==========================================
    // main sequence
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        apb(0, `PAC_OFS_CTRL, 0);
        chk(rd, `PAC_CTRL_RST_VAL);
        apb(0, 4'h2, 0);
        chk(perr, 1'b1);
        chk(rd, 32'h0);
        apb(1, `PAC_OFS_CTRL, 32'h4);
        apb(0, `PAC_OFS_STATUS, 0);
        chk(rd[6], 1'b1);
        apb(1, `PAC_OFS_CTRL, 32'h0);
        ev(6, 1);
        apb(0, `PAC_OFS_STATUS, 0);
        chk(rd[2:0], 3'h2);
        pulse(0, 1); // too short, ignored
        pulse(1, 2); // no reset yet, dropped
        apb(0, `PAC_OFS_STATUS, 0);
        chk(rd[4:3], 2'h0);
        pulse(0, 2);
        chk(hold_st, 3'h3);
        vwatch(15, 16);
        ev(30, 1);
        pulse(1, 2);
        chk(hold_st, 3'h4);
        vwatch(CALN + 15, CALN + 16);
        apb(0, `PAC_OFS_STATUS, 0);
        chk(rd[4], 1'b1);
        ev(1, 0);
        read_n <= 1'b1;
        ev(8, 1);
        apb(0, `PAC_OFS_STATUS, 0);
        chk(rd[7], 1'b0);
        read_n <= 1'b0;
        ev(4, 1);
        apb(0, `PAC_OFS_STATUS, 0);
        chk(rd[7], 1'b1);
        ev(1, 0);
        power_down_n <= 1'b0;
        ev(4, 1);
        chk(cap_valid_n, 1'b1);
        power_down_n <= 1'b1;
        ev(30, 1);
        apb(0, `PAC_OFS_STATUS, 0);
        chk(rd[4:3], 2'h0);
        chk(cap_valid_n, 1'b0);
        // after wake: reset, then recalibrate
        pulse(0, 2);
        chk(hold_st, 3'h3);
        pulse(1, 2);
        chk(hold_st, 3'h4);
        vwatch(CALN + 15, CALN + 16);
        apb(0, `PAC_OFS_STATUS, 0);
        chk(rd[4:3], 2'h3);
        close_out;
    end
endmodule // pac_adc_ctrl_tb
bind pac_adc_ctrl pac_adc_chk chk (.pclk, .presetn, .psel, .penable, .pready, .pslverr, .sample_clk,
    .conv_reset, .cal_req, .read_n, .power_down_n, .data_out, .data_oe, .valid_n);
